/* verilog/cxj_pkg.sv */
package cxj_pkg;

  // ----------------------------------------------------------------
  // Widths and package geometry
  // ----------------------------------------------------------------
  localparam int MEM_AW = 21;
  localparam int WORD_W = 60;
  localparam int REG_W = 18;
  localparam int LEN_W = 21;
  localparam int EXT_W = 24;
  localparam int MASK_W = 6;
  localparam int PKG_WORDS = 16;
  localparam int IDX_W = 4;
  localparam int EXT_SHIFT = 6;
  localparam int PER_RELOC_BIT = 17;

  // ----------------------------------------------------------------
  // Field positions inside a package word and word slots in the package
  // ----------------------------------------------------------------
  localparam int F_ADDR_LSB = 42;
  localparam int F_INDEX_LSB = 24;
  localparam logic [IDX_W-1:0] W_PC = 4'h0;
  localparam logic [IDX_W-1:0] W_BASE = 4'h1;
  localparam logic [IDX_W-1:0] W_LEN = 4'h2;
  localparam logic [IDX_W-1:0] W_MASKS = 4'h3;
  localparam logic [IDX_W-1:0] W_EXT_BASE = 4'h4;
  localparam logic [IDX_W-1:0] W_EXT_LEN = 4'h5;
  localparam logic [IDX_W-1:0] W_MON = 4'h6;

  // ----------------------------------------------------------------
  // Peripheral exchange kinds and executive commands
  // ----------------------------------------------------------------
  localparam logic [1:0] PER_XJ_ANY = 2'h0;
  localparam logic [1:0] PER_XJ_MON = 2'h1;
  localparam logic [1:0] PER_XJ_MON_ADDR = 2'h2;
  localparam logic [1:0] EX_RESUME = 2'h1;
  localparam logic [1:0] EX_HALT = 2'h2;
  localparam logic [1:0] EX_SIM_XJ = 2'h3;

  // ----------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_PKG_ADDR = 8'h08;
  localparam logic [7:0] OFF_PROG_CNT = 8'h0C;
  localparam logic [7:0] OFF_EXEC = 8'h10;
  localparam logic [7:0] OFF_MON_ADDR = 8'h14;
  localparam int ST_MODE = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_HALT = 2;
  localparam logic RST_MODE = 1'b0;
  localparam logic RST_HALT = 1'b1;

  typedef enum logic [2:0] {
    CXJ_IDLE = 3'b001,
    CXJ_READ = 3'b010,
    CXJ_WRITE = 3'b100
  } cxj_state_e;

endpackage

/* verilog/cxj_seq_if.sv */
`timescale 1ns/1ps
// Link between the register keeper and the memory word sequencer.
interface cxj_seq_if;
  import cxj_pkg::*;
  logic start;
  logic [MEM_AW-1:0] base;
  logic [WORD_W-1:0] old_word;
  logic [IDX_W-1:0] idx;
  logic [WORD_W-1:0] new_word;
  logic load;
  logic done;
  modport ctl (output start, base, old_word, input idx, new_word, load, done);
  modport seq (input start, base, old_word, output idx, new_word, load, done);
endinterface

/* verilog/cxj_mem_seq.sv */
`timescale 1ns/1ps
// Walks the sixteen package words: read the incoming word, then write the outgoing one.
module cxj_mem_seq
(
  input wire logic mclk,
  input wire logic rst_n,
  cxj_seq_if.seq link,
  output logic mem_req_q,
  output logic mem_we_q,
  output logic [cxj_pkg::MEM_AW-1:0] mem_addr_q,
  output logic [cxj_pkg::WORD_W-1:0] mem_wdata_q,
  input wire logic mem_ack,
  input wire logic [cxj_pkg::WORD_W-1:0] mem_rdata
);
  import cxj_pkg::*;

  cxj_state_e state_q;
  logic [MEM_AW-1:0] base_q;
  logic [IDX_W-1:0] idx_q;
  logic [WORD_W-1:0] new_q;
  logic load_q;
  logic done_q;

  assign link.idx = idx_q;
  assign link.new_word = new_q;
  assign link.load = load_q;
  assign link.done = done_q;

  // ----------------------------------------------------------------
  // Word sequencing
  // ----------------------------------------------------------------
  // Reading first keeps the old image in the registers until the write is taken,
  // so the outgoing word is never lost if memory stalls.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= CXJ_IDLE;
      base_q <= '0;
      idx_q <= '0;
      new_q <= '0;
      load_q <= 1'b0;
      done_q <= 1'b0;
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_addr_q <= '0;
      mem_wdata_q <= '0;
    end
    else
    begin
      load_q <= 1'b0;
      done_q <= 1'b0;
      case (state_q)
        CXJ_IDLE:
        begin
          if (link.start)
          begin
            base_q <= link.base;
            idx_q <= '0;
            state_q <= CXJ_READ;
          end
        end
        CXJ_READ:
        begin
          // Wait out the load cycle, so the address sees the advanced index.
          if (!mem_req_q && !load_q)
          begin
            mem_req_q <= 1'b1;
            mem_we_q <= 1'b0;
            mem_addr_q <= MEM_AW'(base_q + MEM_AW'(idx_q));
          end
          else if (mem_req_q && mem_ack)
          begin
            mem_req_q <= 1'b0;
            new_q <= mem_rdata;
            state_q <= CXJ_WRITE;
          end
        end
        CXJ_WRITE:
        begin
          if (!mem_req_q && !load_q)
          begin
            mem_req_q <= 1'b1;
            mem_we_q <= 1'b1;
            mem_wdata_q <= link.old_word;
          end
          else if (mem_req_q && mem_ack)
          begin
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            load_q <= 1'b1;
            if (idx_q == IDX_W'(PKG_WORDS - 1))
            begin
              done_q <= 1'b1;
              state_q <= CXJ_IDLE;
            end
            else
            begin
              state_q <= CXJ_READ;
            end
          end
        end
        default:
        begin
          state_q <= CXJ_IDLE;
        end
      endcase
      if (load_q)
      begin
        idx_q <= IDX_W'(idx_q + 1'b1);
      end
    end
  end

endmodule // cxj_mem_seq

/* verilog/cxj_exchange_unit.sv */
`timescale 1ns/1ps
// Exchange unit: holds the processor state image and swaps it with memory.
module cxj_exchange_unit
#(
  parameter int ADDR_W = cxj_pkg::MEM_AW
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cpu_xj_req,
  input wire logic [2:0] cpu_xj_index,
  input wire logic [cxj_pkg::REG_W-1:0] cpu_xj_const,
  input wire logic per_xj_req,
  input wire logic [1:0] per_xj_kind,
  input wire logic [cxj_pkg::REG_W-1:0] per_accumulator,
  input wire logic [cxj_pkg::MEM_AW-1:0] per_relocation,
  output logic per_xj_pass,
  output logic mem_req,
  output logic mem_we,
  output logic [cxj_pkg::MEM_AW-1:0] mem_addr,
  output logic [cxj_pkg::WORD_W-1:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [cxj_pkg::WORD_W-1:0] mem_rdata,
  output logic monitor_mode_flag,
  output logic xj_busy,
  output logic issue_enable,
  output logic fetch_restart,
  output logic [cxj_pkg::REG_W-1:0] fetch_pc,
  output logic [29:0] extended_memory_base,
  output logic [29:0] extended_memory_length
);
  import cxj_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The sequencer and the memory port are built at the package address width.
  if (ADDR_W != MEM_AW)
  begin : g_bad_width
    $error("cxj_exchange_unit: ADDR_W must equal the memory address width");
  end

  // ----------------------------------------------------------------
  // State image held in the processor registers
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] x_q [8];
  logic [REG_W-1:0] a_q [8];
  logic [REG_W-1:0] b_q [8];
  logic [REG_W-1:0] pc_q;
  logic [LEN_W-1:0] memory_base_address_q;
  logic [LEN_W-1:0] memory_field_length_q;
  logic [MASK_W-1:0] exit_mode_mask_q;
  logic [MASK_W-1:0] flags_q;
  logic [EXT_W-1:0] ext_base_q;
  logic [EXT_W-1:0] ext_len_q;
  logic [REG_W-1:0] monitor_base_address_q;

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  logic mode_q;
  logic busy_q;
  logic halted_q;
  logic expanded_q;
  logic start_q;
  logic [MEM_AW-1:0] pkg_addr_q;
  logic [1:0] exec_cmd_q;

  cxj_seq_if link ();

  cxj_mem_seq u_seq (
    .mclk(mclk),
    .rst_n(rst_n),
    .link(link),
    .mem_req_q(mem_req),
    .mem_we_q(mem_we),
    .mem_addr_q(mem_addr),
    .mem_wdata_q(mem_wdata),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata)
  );

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Index register zero is a constant, so any read of it yields zero.
  function automatic logic [REG_W-1:0] index_val(input logic [2:0] j);
    index_val = (j == 3'h0) ? '0 : b_q[j];
  endfunction

  // Peripheral address: accumulator, relocated when its top bit asks for it.
  function automatic logic [MEM_AW-1:0] per_addr(input logic [REG_W-1:0] acc);
    if (acc[PER_RELOC_BIT])
    begin
      per_addr = MEM_AW'(MEM_AW'(acc) + per_relocation);
    end
    else
    begin
      per_addr = MEM_AW'(acc);
    end
  endfunction

  // Outgoing word for a package slot; low words mix address, index and control images.
  function automatic logic [WORD_W-1:0] pkg_word(input logic [IDX_W-1:0] i);
    logic [23:0] misc;
    misc = '0;
    case (i)
      W_PC: misc = 24'(pc_q);
      W_BASE: misc = 24'(memory_base_address_q);
      W_LEN: misc = 24'(memory_field_length_q);
      W_MASKS: misc = {12'h000, exit_mode_mask_q, flags_q};
      W_EXT_BASE: misc = ext_base_q;
      W_EXT_LEN: misc = ext_len_q;
      W_MON: misc = 24'(monitor_base_address_q);
      default: misc = '0;
    endcase
    if (i[3])
    begin
      pkg_word = x_q[i[2:0]];
    end
    else
    begin
      pkg_word = {a_q[i[2:0]], index_val(i[2:0]), misc};
    end
  endfunction

  assign link.start = start_q;
  assign link.base = pkg_addr_q;

  // A process, not an assignment, so that it also wakes on the registers it reads.
  always_comb
  begin
    link.old_word = pkg_word(link.idx);
  end

  // ----------------------------------------------------------------
  // Exchange request acceptance
  // ----------------------------------------------------------------
  // Requests are taken only while idle; the processor request wins a same-cycle tie.
  // A request that lands during an exchange is dropped, since the requester holds
  // no pending slot here and must retry after xj_busy falls.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_q <= 1'b0;
      busy_q <= 1'b0;
      pkg_addr_q <= '0;
      per_xj_pass <= 1'b0;
    end
    else
    begin
      start_q <= 1'b0;
      per_xj_pass <= 1'b0;
      if (link.done)
      begin
        busy_q <= 1'b0;
      end
      else if (!busy_q && !start_q)
      begin
        if (cpu_xj_req)
        begin
          busy_q <= 1'b1;
          start_q <= 1'b1;
          if (mode_q)
          begin
            pkg_addr_q <= MEM_AW'(index_val(cpu_xj_index) + cpu_xj_const);
          end
          else
          begin
            pkg_addr_q <= MEM_AW'(monitor_base_address_q);
          end
        end
        else if (exec_cmd_q == EX_SIM_XJ && !mode_q)
        begin
          busy_q <= 1'b1;
          start_q <= 1'b1;
          pkg_addr_q <= MEM_AW'(monitor_base_address_q);
        end
        else if (per_xj_req)
        begin
          if (per_xj_kind != PER_XJ_ANY && mode_q)
          begin
            per_xj_pass <= 1'b1;
          end
          else
          begin
            busy_q <= 1'b1;
            start_q <= 1'b1;
            if (per_xj_kind == PER_XJ_MON_ADDR)
            begin
              pkg_addr_q <= MEM_AW'(monitor_base_address_q);
            end
            else
            begin
              pkg_addr_q <= per_addr(per_accumulator);
            end
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode flag and run control
  // ----------------------------------------------------------------
  // The mode flips only when the last word is loaded, so a half-done swap never
  // shows the new mode. An exchange also starts a halted processor.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_q <= RST_MODE;
      halted_q <= RST_HALT;
    end
    else if (link.done)
    begin
      mode_q <= !mode_q;
      halted_q <= 1'b0;
    end
    else if (exec_cmd_q == EX_HALT)
    begin
      halted_q <= 1'b1;
    end
    else if (exec_cmd_q == EX_RESUME)
    begin
      halted_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Loading the incoming package
  // ----------------------------------------------------------------
  // Each word lands right after its outgoing twin was written, so registers hold
  // the old image until then and stay put between exchanges.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int k = 0; k < 8; k++)
      begin
        x_q[k] <= '0;
        a_q[k] <= '0;
        b_q[k] <= '0;
      end
      pc_q <= '0;
      memory_base_address_q <= '0;
      memory_field_length_q <= '0;
      exit_mode_mask_q <= '0;
      flags_q <= '0;
      ext_base_q <= '0;
      ext_len_q <= '0;
      monitor_base_address_q <= '0;
    end
    else if (link.load)
    begin
      if (link.idx[3])
      begin
        x_q[link.idx[2:0]] <= link.new_word;
      end
      else
      begin
        a_q[link.idx[2:0]] <= link.new_word[F_ADDR_LSB +: REG_W];
        if (link.idx[2:0] != 3'h0)
        begin
          b_q[link.idx[2:0]] <= link.new_word[F_INDEX_LSB +: REG_W];
        end
        case (link.idx)
          W_PC: pc_q <= link.new_word[REG_W-1:0];
          W_BASE: memory_base_address_q <= link.new_word[LEN_W-1:0];
          W_LEN: memory_field_length_q <= link.new_word[LEN_W-1:0];
          W_MASKS:
          begin
            exit_mode_mask_q <= link.new_word[2*MASK_W-1:MASK_W];
            flags_q <= link.new_word[MASK_W-1:0];
          end
          W_EXT_BASE: ext_base_q <= link.new_word[EXT_W-1:0];
          W_EXT_LEN: ext_len_q <= link.new_word[EXT_W-1:0];
          W_MON: monitor_base_address_q <= link.new_word[REG_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Processor-facing outputs
  // ----------------------------------------------------------------
  // Issue stays off from acceptance to the cycle after the last load, so
  // no instruction slips in between the swap words.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      monitor_mode_flag <= RST_MODE;
      xj_busy <= 1'b0;
      issue_enable <= 1'b0;
      fetch_restart <= 1'b0;
      fetch_pc <= '0;
    end
    else
    begin
      // Mode and busy change in the same cycle as the restart pulse.
      monitor_mode_flag <= mode_q ^ link.done;
      xj_busy <= (busy_q || start_q) && !link.done;
      issue_enable <= !busy_q && !start_q && !halted_q && !link.done;
      fetch_restart <= link.done;
      fetch_pc <= pc_q;
    end
  end

  // Standard mode keeps 21 significant bits; both modes append six zero bits.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      extended_memory_base <= '0;
      extended_memory_length <= '0;
    end
    else if (expanded_q)
    begin
      extended_memory_base <= {ext_base_q, 6'h00};
      extended_memory_length <= {ext_len_q, 6'h00};
    end
    else
    begin
      extended_memory_base <= {3'h0, ext_base_q[LEN_W-1:0], 6'h00};
      extended_memory_length <= {3'h0, ext_len_q[LEN_W-1:0], 6'h00};
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // Every access is answered one cycle after it is presented; unmapped reads give zero.
  logic bus_hit;
  assign bus_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      expanded_q <= 1'b0;
      exec_cmd_q <= '0;
    end
    else
    begin
      wb_ack_o <= bus_hit;
      exec_cmd_q <= '0;
      wb_dat_o <= '0;
      if (bus_hit && wb_we_i && wb_sel_i[0])
      begin
        if (wb_adr_i == OFF_CTRL)
        begin
          expanded_q <= wb_dat_i[0];
        end
        else if (wb_adr_i == OFF_EXEC)
        begin
          exec_cmd_q <= wb_dat_i[1:0];
        end
      end
      else if (bus_hit && !wb_we_i)
      begin
        case (wb_adr_i)
          OFF_CTRL: wb_dat_o <= {31'h0, expanded_q};
          OFF_STATUS: wb_dat_o <= {29'h0, halted_q, busy_q || start_q, mode_q};
          OFF_PKG_ADDR: wb_dat_o <= 32'(pkg_addr_q);
          OFF_PROG_CNT: wb_dat_o <= 32'(pc_q);
          OFF_MON_ADDR: wb_dat_o <= 32'(monitor_base_address_q);
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end

endmodule // cxj_exchange_unit

/* sim/cxj_mem_model.sv */
`timescale 1ns/1ps
// --------------------------------
// Central memory stand-in.
// --------------------------------
module cxj_mem_model
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] lat,
  input wire logic mem_req,
  input wire logic [20:0] mem_addr,
  output logic mem_ack,
  output logic [59:0] mem_rdata
);
  logic [3:0] wait_q;
  // Answers after lat cycles; data toggles off the ack so stale use shows.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_q <= 4'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 60'h0;
    end
    else if (mem_req && !mem_ack && wait_q == lat)
    begin
      wait_q <= 4'h0;
      mem_ack <= 1'b1;
      mem_rdata <= {mem_addr[17:0], 18'(mem_addr + 21'h1), 24'(mem_addr + 21'h100)};
    end
    else
    begin
      wait_q <= (mem_req && !mem_ack) ? wait_q + 4'h1 : 4'h0;
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // cxj_mem_model

/* sim/cxj_exchange_unit_asserts.sv */
`timescale 1ns/1ps
// --------------------------------
// Port checker for the exchange unit.
// --------------------------------
module cxj_exchange_unit_asserts
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cpu_xj_req,
  input wire logic per_xj_req,
  input wire logic [1:0] per_xj_kind,
  input wire logic per_xj_pass,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [20:0] mem_addr,
  input wire logic [59:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic monitor_mode_flag,
  input wire logic xj_busy,
  input wire logic issue_enable,
  input wire logic fetch_restart,
  input wire logic [29:0] extended_memory_base,
  input wire logic [29:0] extended_memory_length
);
  import cxj_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Mode changes only at the end of an exchange, and never while issuing.
  a_busy_no_issue: assert property (xj_busy |-> !issue_enable)
    else $error("issue enabled during exchange");
  a_end_drops_busy: assert property (fetch_restart |-> $fell(xj_busy))
    else $error("restart without end of exchange");
  a_mode_flips: assert property (fetch_restart |->
    monitor_mode_flag != $past(monitor_mode_flag)) else $error("mode did not flip");
  a_mode_holds: assert property (!fetch_restart |-> $stable(monitor_mode_flag))
    else $error("mode changed outside exchange");
  a_pass_cause: assert property (per_xj_pass |-> $past(per_xj_req) &&
    $past(per_xj_kind) != PER_XJ_ANY && monitor_mode_flag && !xj_busy)
    else $error("bad pass pulse");
  a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) &&
    $stable(mem_we) && $stable(mem_wdata)) else $error("memory request moved");
  a_mem_in_xj: assert property (mem_req |-> xj_busy)
    else $error("memory access outside exchange");
  a_ext_low_zero: assert property (extended_memory_base[5:0] == 6'h0 &&
    extended_memory_length[5:0] == 6'h0) else $error("extended low bits set");
  a_req_starts: assert property (cpu_xj_req && !xj_busy |-> ##[1:2] xj_busy)
    else $error("request did not start exchange");
  c_exchange: cover property (fetch_restart);
  c_pass: cover property (per_xj_pass);
  c_write: cover property (mem_req && mem_we && mem_ack);
endmodule // cxj_exchange_unit_asserts

bind cxj_exchange_unit cxj_exchange_unit_asserts i_chk (.mclk, .rst_n, .cpu_xj_req,
  .per_xj_req, .per_xj_kind, .per_xj_pass, .mem_req, .mem_we, .mem_addr, .mem_wdata,
  .mem_ack, .monitor_mode_flag, .xj_busy, .issue_enable, .fetch_restart,
  .extended_memory_base, .extended_memory_length);

/* sim/tb_cxj_exchange_unit.sv */
`timescale 1ns/1ps
// --------------------------------
// Exchange unit bench.
// --------------------------------
module tb_cxj_exchange_unit;
  import cxj_pkg::*;
  logic mclk = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
  logic [7:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 0, lat = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
  logic cpu_xj_req = 0, per_xj_req = 0, per_xj_pass, mem_req, mem_we, mem_ack;
  logic [2:0] cpu_xj_index = 0;
  logic [17:0] cpu_xj_const = 0, per_accumulator = 0, fetch_pc;
  logic [1:0] per_xj_kind = 0;
  logic [20:0] per_relocation = 0, mem_addr, first_a;
  logic [59:0] mem_wdata, mem_rdata, first_w;
  logic monitor_mode_flag, xj_busy, issue_enable, fetch_restart, got_a, got_w;
  logic [29:0] extended_memory_base, extended_memory_length;
  int err_count = 0, compares = 0, cyc_n = 0;

  cxj_exchange_unit i_dut (.mclk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cpu_xj_req, .cpu_xj_index, .cpu_xj_const,
    .per_xj_req, .per_xj_kind, .per_accumulator, .per_relocation, .per_xj_pass, .mem_req,
    .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .monitor_mode_flag, .xj_busy,
    .issue_enable, .fetch_restart, .fetch_pc, .extended_memory_base,
    .extended_memory_length);
  cxj_mem_model i_mem (.mclk, .rst_n, .lat, .mem_req, .mem_addr, .mem_ack, .mem_rdata);

  always #5 mclk = ~mclk;

  // A hang counts as a mismatch and ends the run.
  always @(posedge mclk)
  begin
    cyc_n++;
    if (cyc_n == 20000)
    begin
      err_count++;
      close_out();
    end
  end

  // Keep the package address and the first outgoing word of each exchange.
  always @(posedge mclk)
  begin
    if (mem_req && mem_ack && !mem_we && !got_a)
    begin
      got_a = 1;
      first_a = mem_addr;
    end
    if (mem_req && mem_ack && mem_we && !got_w)
    begin
      got_w = 1;
      first_w = mem_wdata;
    end
  end

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Classic single cycle; held until ack is sampled high.
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge mclk);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do @(posedge mclk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    wb_we_i <= 0;
  endtask

  task automatic cpu_go(logic [2:0] j, logic [17:0] k);
    @(posedge mclk);
    cpu_xj_req <= 1;
    cpu_xj_index <= j;
    cpu_xj_const <= k;
    @(posedge mclk);
    cpu_xj_req <= 0;
  endtask

  task automatic per_go(logic [1:0] kd, logic [17:0] acc, logic [20:0] rel);
    @(posedge mclk);
    per_xj_req <= 1;
    per_xj_kind <= kd;
    per_accumulator <= acc;
    per_relocation <= rel;
    @(posedge mclk);
    per_xj_req <= 0;
  endtask

  // Memory words carry address-derived images: pc is base plus 100h.
  task automatic xj_wait(logic [20:0] a, logic m);
    got_a = 0;
    got_w = 0;
    do @(posedge mclk); while (fetch_restart !== 1'b1);
    chk("package address", 32'(first_a), 32'(a));
    chk("mode", 32'(monitor_mode_flag), 32'(m));
    chk("fetch pc", 32'(fetch_pc), 32'(18'(a + 21'h100)));
  endtask

  task automatic t_reset();
    chk("reset mode", 32'(monitor_mode_flag), 32'h0);
    chk("reset issue", 32'(issue_enable), 32'h0);
    wb(0, OFF_STATUS, 0);
    chk("status", rd, 32'h4);
    wb(0, 8'h20, 0);
    chk("unmapped", rd, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_exec();
    wb(1, OFF_EXEC, 32'(EX_RESUME));
    repeat (2) @(posedge mclk);
    chk("resume", 32'(issue_enable), 32'h1);
    wb(1, OFF_EXEC, 32'(EX_HALT));
    repeat (2) @(posedge mclk);
    chk("halt", 32'(issue_enable), 32'h0);
    wb(1, OFF_EXEC, 32'(EX_SIM_XJ));
    xj_wait(21'h0, 1);
    $display("test exec done");
  endtask

  task automatic t_pass();
    for (int k = 1; k < 3; k++)
    begin
      per_go(2'(k), 18'h00030, 21'h0);
      @(posedge mclk);
      chk("pass", 32'(per_xj_pass), 32'h1);
      chk("no busy", 32'(xj_busy), 32'h0);
    end
    $display("test pass done");
  endtask

  task automatic t_cp();
    lat <= 4'h3;
    cpu_go(3'h3, 18'h00040);
    xj_wait(21'h44, 0);
    chk("outgoing pc", 32'(first_w[17:0]), 32'h100);
    cpu_go(3'h0, 18'h0);
    xj_wait(21'h14A, 1);
    chk("outgoing pc", 32'(first_w[17:0]), 32'h144);
    cpu_go(3'h0, 18'h00060);
    xj_wait(21'h60, 0);
    $display("test cp done");
  endtask

  task automatic t_pp();
    lat <= 4'h0;
    wb(1, OFF_CTRL, 32'h1);
    per_go(PER_XJ_MON, 18'h20010, 21'h80);
    xj_wait(21'h20090, 1);
    per_go(PER_XJ_ANY, 18'h00050, 21'h80);
    xj_wait(21'h50, 0);
    chk("ext base", 32'(extended_memory_base), 32'h5500);
    chk("ext length", 32'(extended_memory_length), 32'h5540);
    per_go(PER_XJ_MON_ADDR, 18'h0, 21'h0);
    xj_wait(21'h156, 1);
    wb(0, OFF_PKG_ADDR, 0);
    chk("package address reg", rd, 32'h156);
    wb(0, OFF_MON_ADDR, 0);
    chk("monitor address reg", rd, 32'h25C);
    wb(0, OFF_PROG_CNT, 0);
    chk("counter reg", rd, 32'h256);
    wb(0, OFF_CTRL, 0);
    chk("control reg", rd, 32'h1);
    $display("test pp done");
  endtask

  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Reset for two cycles, then the scenarios in order.
  initial
  begin
    repeat (2) @(posedge mclk);
    rst_n <= 1;
    t_reset();
    t_exec();
    t_pass();
    t_cp();
    t_pp();
    close_out();
  end
endmodule // tb_cxj_exchange_unit
